//--- hdl/ewt_defs.svh
`ifndef EWT_DEFS_SVH
`define EWT_DEFS_SVH

// Register byte offsets
`define EWT_OFF_SC        12'h000
`define EWT_OFF_CLK       12'h004
`define EWT_OFF_CNT       12'h008
`define EWT_OFF_MOD       12'h00c

// Status and control field positions
`define EWT_SC_TOF        7
`define EWT_SC_OVERFLOW_IRQ_ENABLE       6
`define EWT_SC_TRST       5
`define EWT_SC_HALT       4

// Clock config field positions
`define EWT_CLK_CS_LSB    4
`define EWT_CLK_PS_LSB    0

// Reset values
`define EWT_SC_RST        8'h10
`define EWT_CLK_RST       8'h00
`define EWT_MOD_RST       8'h00

// Fixed clock divider from mclk
`define EWT_FIX_DIV       8'h04

`endif

//--- hdl/ewt_pkg.sv
package ewt_pkg;

  typedef enum logic [3:0] {
    EWT_SRC_BUS  = 4'b0001,
    EWT_SRC_FIX  = 4'b0010,
    EWT_SRC_EXTR = 4'b0100,
    EWT_SRC_EXTF = 4'b1000
  } ewt_src_t;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ewt_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ewt_apb_rsp_t;

  typedef struct packed {
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic        halt;
    logic [1:0]  cs;
    logic [3:0]  ps;
    logic [7:0]  wrap;
    logic [7:0]  cnt;
    logic [7:0]  pre;
    logic [7:0]  fix_div;
    logic        fix_tick;
    logic        ext_q;
    logic        irq;
    logic        tof_read;
    ewt_apb_rsp_t rsp;
  } ewt_state_t;

endpackage

//--- hdl/ewt_timer.sv
// The APB slave port and the register addresses were left to the implementer.
`include "ewt_defs.svh"

// Overview of operation
// - Counting clock from bus, fixed, external rising or external falling.
// - Prescaler divides chosen clock by 1,2,4,8,16,32,64 or 256.
// - At nonzero limit, wait one more tick then return counter to zero.
// - Limit zero means free run, overflow after count 0xff.
// - Overflow flag sets on the tick the counter goes to zero.
// - Interrupt asserted while overflow flag and its enable are set.
// - Control lets firmware reset, stop, pick source and prescale.
// - Count register readable; separate register holds wrap limit.
module ewt_timer (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire ewt_pkg::ewt_apb_req_t apb_req,
  input  wire logic                  ext_ref,
  output logic                       irq,
  output ewt_pkg::ewt_apb_rsp_t      apb_rsp
);

  ewt_pkg::ewt_state_t st_r;
  ewt_pkg::ewt_state_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [7:0] ps_mask(input logic [3:0] ps);
    case (ps)
      4'h0:    ps_mask = 8'h00;
      4'h1:    ps_mask = 8'h01;
      4'h2:    ps_mask = 8'h03;
      4'h3:    ps_mask = 8'h07;
      4'h4:    ps_mask = 8'h0f;
      4'h5:    ps_mask = 8'h1f;
      4'h6:    ps_mask = 8'h3f;
      default: ps_mask = 8'hff;
    endcase
  endfunction

  function automatic ewt_pkg::ewt_src_t src_dec(input logic [1:0] cs);
    case (cs)
      2'h0:    src_dec = ewt_pkg::EWT_SRC_BUS;
      2'h1:    src_dec = ewt_pkg::EWT_SRC_FIX;
      2'h2:    src_dec = ewt_pkg::EWT_SRC_EXTR;
      default: src_dec = ewt_pkg::EWT_SRC_EXTF;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic       src_tick;
  logic       pre_tick;
  logic       wrap_pt;
  logic       acc;
  logic       wr;
  logic [7:0] wd;
  logic [7:0] rd;

  always_comb begin
    st_nxt     = st_r;
    acc        = apb_req.psel && apb_req.penable;
    wr         = acc && apb_req.pwrite;
    wd         = apb_req.pwdata[7:0];
    rd         = 8'h00;
    // Fixed clock tick
    st_nxt.fix_tick = 1'b0;
    if (st_r.fix_div == `EWT_FIX_DIV - 8'h01) begin
      st_nxt.fix_div  = 8'h00;
      st_nxt.fix_tick = 1'b1;
    end else begin
      st_nxt.fix_div = st_r.fix_div + 8'h01;
    end
    st_nxt.ext_q = ext_ref;
    case (src_dec(st_r.cs))
      ewt_pkg::EWT_SRC_BUS:  src_tick = 1'b1;
      ewt_pkg::EWT_SRC_FIX:  src_tick = st_r.fix_tick;
      ewt_pkg::EWT_SRC_EXTR: src_tick = ext_ref && !st_r.ext_q;
      ewt_pkg::EWT_SRC_EXTF: src_tick = !ext_ref && st_r.ext_q;
      default:               src_tick = 1'b0;
    endcase
    pre_tick = 1'b0;
    wrap_pt  = (st_r.wrap == 8'h00) ? (st_r.cnt == 8'hff)
                                    : (st_r.cnt == st_r.wrap);
    if (!st_r.halt && src_tick) begin
      if ((st_r.pre & ps_mask(st_r.ps)) == ps_mask(st_r.ps)) begin
        st_nxt.pre = 8'h00;
        pre_tick   = 1'b1;
      end else begin
        st_nxt.pre = st_r.pre + 8'h01;
      end
    end
    // Software side
    if (acc && !apb_req.pwrite && apb_req.paddr == `EWT_OFF_SC &&
        st_r.overflow_flag) begin
      st_nxt.tof_read = 1'b1;
    end
    if (wr) begin
      case (apb_req.paddr)
        `EWT_OFF_SC: begin
          st_nxt.overflow_irq_enable = wd[`EWT_SC_OVERFLOW_IRQ_ENABLE];
          st_nxt.halt = wd[`EWT_SC_HALT];
          if (!wd[`EWT_SC_TOF] && st_r.tof_read) begin
            st_nxt.overflow_flag      = 1'b0;
            st_nxt.tof_read = 1'b0;
          end
          if (wd[`EWT_SC_TRST]) begin
            st_nxt.cnt = 8'h00;
            st_nxt.pre = 8'h00;
            pre_tick   = 1'b0;
          end
        end
        `EWT_OFF_CLK: begin
          st_nxt.cs = wd[`EWT_CLK_CS_LSB +: 2];
          st_nxt.ps = wd[`EWT_CLK_PS_LSB +: 4];
        end
        `EWT_OFF_MOD: begin
          st_nxt.wrap = wd;
          st_nxt.cnt  = 8'h00;
          st_nxt.pre  = 8'h00;
          pre_tick    = 1'b0;
        end
        default: ;
      endcase
    end
    if (pre_tick) begin
      if (wrap_pt) begin
        st_nxt.cnt      = 8'h00;
        st_nxt.overflow_flag      = 1'b1;
        st_nxt.tof_read = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end
    st_nxt.irq = st_nxt.overflow_flag && st_nxt.overflow_irq_enable;
    // Read mux
    case (apb_req.paddr)
      `EWT_OFF_SC:  rd = {st_r.overflow_flag, st_r.overflow_irq_enable, 1'b0, st_r.halt, 4'h0};
      `EWT_OFF_CLK: rd = {2'b00, st_r.cs, st_r.ps};
      `EWT_OFF_CNT: rd = st_r.cnt;
      `EWT_OFF_MOD: rd = st_r.wrap;
      default:      rd = 8'h00;
    endcase
    st_nxt.rsp.pready  = 1'b1;
    st_nxt.rsp.pslverr = 1'b0;
    st_nxt.rsp.prdata  = 32'h0;
    if (apb_req.psel && !apb_req.penable) begin
      st_nxt.rsp.prdata  = {24'h0, rd};
      st_nxt.rsp.pslverr = !(apb_req.paddr == `EWT_OFF_SC ||
                             apb_req.paddr == `EWT_OFF_CLK ||
                             apb_req.paddr == `EWT_OFF_CNT ||
                             apb_req.paddr == `EWT_OFF_MOD);
    end else if (acc) begin
      st_nxt.rsp.prdata  = st_r.rsp.prdata;
      st_nxt.rsp.pslverr = st_r.rsp.pslverr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.halt     <= 1'b1;
      st_r.rsp.pready <= 1'b1;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign irq     = st_r.irq;
  assign apb_rsp = st_r.rsp;

endmodule

//--- tb/ewt_timer_chk.sv
module ewt_timer_chk (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  clk_en,
  input wire ewt_pkg::ewt_apb_req_t apb_req,
  input wire logic                  ext_ref,
  input wire logic                  irq,
  input wire ewt_pkg::ewt_apb_rsp_t apb_rsp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic su;
  logic ac;
  logic um;
  assign su = apb_req.psel && !apb_req.penable && clk_en;
  assign ac = apb_req.psel && apb_req.penable;
  assign um = apb_req.paddr[11:4] != 8'h00;
  //////////////////////////////////////////////////////////////////////////
  ready_high_a: assert property (apb_rsp.pready)
    else $error("pready low");
  unmap_err_a: assert property (su && um |=> apb_rsp.pslverr)
    else $error("no error on unmapped");
  map_ok_a: assert property (su && !um && apb_req.paddr[1:0] == 2'h0
    |=> !apb_rsp.pslverr) else $error("error on mapped");
  upper_zero_a: assert property (ac |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmap_rd_a: assert property (ac && um && $past(clk_en)
    |-> apb_rsp.prdata == 32'h0) else $error("unmapped read data");
  rst_bit_a: assert property (ac && apb_req.paddr == 12'h0 && $past(clk_en)
    |-> !apb_rsp.prdata[5]) else $error("reset bit reads one");
  irq_mask_a: assert property (ac && apb_req.pwrite && clk_en
    && apb_req.paddr == 12'h0 && !apb_req.pwdata[6] ##1 clk_en |=> !irq)
    else $error("irq with enable off");
  freeze_a: assert property (!clk_en |=> $stable(apb_rsp) && $stable(irq))
    else $error("state moved while frozen");
  unmap_c: cover property (su && um);
  irq_c: cover property ($rose(irq));
  freeze_c: cover property (!clk_en);
endmodule
//////////////////////////////////////////////////////////////////////////
bind ewt_timer ewt_timer_chk u_chk (.mclk(mclk), .sys_rst(sys_rst),
  .clk_en(clk_en), .apb_req(apb_req), .ext_ref(ext_ref), .irq(irq),
  .apb_rsp(apb_rsp));

//--- tb/ewt_timer_tb.sv
`include "ewt_defs.svh"
module ewt_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk = 1'b0;
  logic                  sys_rst = 1'b1;
  logic                  clk_en = 1'b1;
  logic                  ext_ref = 1'b0;
  logic                  irq;
  logic                  rerr;
  logic [7:0]            rdat;
  ewt_pkg::ewt_apb_req_t req = '0;
  ewt_pkg::ewt_apb_rsp_t apb_rsp;
  int                    n_errors = 0;
  int                    num_checks = 0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) ext_ref <= ~ext_ref;
  ewt_timer DUT (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en),
    .apb_req(req), .ext_ref(ext_ref), .irq(irq), .apb_rsp(apb_rsp));
  //////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] a, input logic [7:0] e, g);
    num_checks++;
    if (g !== e) begin
      $display("BAD reg %h exp %h got %h", a, e, g);
      n_errors++;
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:{24'h0, d}};
    @(posedge mclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      print_verdict();
    end
    rdat = apb_rsp.prdata[7:0];
    rerr = apb_rsp.pslverr;
    req <= '0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(a, e, rdat);
  endtask
  task automatic period(input logic [7:0] ck, lim, input int exp);
    int n;
    bus(1'b1, `EWT_OFF_SC, 8'h10);
    bus(1'b1, `EWT_OFF_CLK, ck);
    bus(1'b1, `EWT_OFF_MOD, lim);
    bus(1'b0, `EWT_OFF_SC, 8'h00);
    bus(1'b1, `EWT_OFF_SC, 8'h60);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((irq !== 1'b1 || n < 2) && n < 3000);
    num_checks++;
    if (n < exp - 2 || n > exp + 4) begin
      $display("BAD period exp %0d got %0d", exp, n);
      n_errors++;
    end
    if (n >= 3000)
      print_verdict();
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`EWT_OFF_SC, `EWT_SC_RST);
    rd(`EWT_OFF_CLK, `EWT_CLK_RST);
    rd(`EWT_OFF_MOD, `EWT_MOD_RST);
    bus(1'b1, `EWT_OFF_CNT, 8'haa);
    rd(`EWT_OFF_CNT, 8'h00);
    rd(12'h010, 8'h00);
    chk(12'h010, 8'h01, {7'h0, rerr});
    $display("test regs done");
    for (int p = 0; p < 8; p++) begin
      period(8'(p), 8'h03, (p == 7) ? 1024 : 4 << p);
    end
    period(8'h00, 8'h00, 256);
    period(8'h10, 8'h03, 16);
    period(8'h20, 8'h03, 8);
    period(8'h30, 8'h03, 8);
    $display("test periods done");
    bus(1'b1, `EWT_OFF_SC, 8'h50);
    rd(`EWT_OFF_SC, 8'hd0);
    bus(1'b1, `EWT_OFF_SC, 8'h50);
    rd(`EWT_OFF_SC, 8'h50);
    chk(12'h000, 8'h00, {7'h0, irq});
    bus(1'b1, `EWT_OFF_SC, 8'h00);
    clk_en <= 1'b0;
    repeat (5) @(posedge mclk);
    clk_en <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(12'h000, 8'h00, {7'h0, irq});
    rd(`EWT_OFF_SC, 8'h80);
    $display("test flag done");
    print_verdict();
  end
endmodule
